// *** logic/lsb_clock_pkg.sv ***
// constants and types for the low-speed bus clock gates and backup clock control
// assumes one 50 MHz system clock and an AXI4-Lite master with 32-bit data
`default_nettype none

package lsb_clock_pkg;

  // ==========================================================================
  // register map (byte addresses, one aligned word each)
  localparam logic [7:0]  GATES_OFFSET     = 8'h1c;
  localparam logic [7:0]  BDCTL_OFFSET     = 8'h20;
  localparam int          ADDR_W           = 8;

  // ==========================================================================
  // clock gate register layout
  localparam logic [31:0] GATES_RESET      = 32'h0000_0000;
  localparam logic [31:0] GATES_WR_MASK    = 32'h3e7e_c83f;
  localparam int          DAC_GATE_BIT     = 29;
  localparam int          POWER_GATE_BIT   = 28;
  localparam int          BKPIF_GATE_BIT   = 27;
  localparam int          CAN_B_GATE_BIT   = 26;
  localparam int          CAN_A_GATE_BIT   = 25;
  localparam int          I2C_B_GATE_BIT   = 22;
  localparam int          I2C_A_GATE_BIT   = 21;
  localparam int          SERIAL_E_BIT     = 20;
  localparam int          SERIAL_B_BIT     = 17;
  localparam int          SPI_C_GATE_BIT   = 15;
  localparam int          SPI_B_GATE_BIT   = 14;
  localparam int          WWDG_GATE_BIT    = 11;
  localparam int          TIMER_G_BIT      = 5;
  localparam int          TIMER_B_BIT      = 0;

  // ==========================================================================
  // backup domain control register layout
  localparam logic [31:0] BDCTL_RESET      = 32'h0000_0018;
  localparam logic [31:0] BDCTL_RSVD_READ  = 32'h0000_0018;
  localparam int          BD_ENABLE_BIT    = 0;
  localparam int          BD_STABLE_BIT    = 1;
  localparam int          BD_BYPASS_BIT    = 2;
  localparam int          BD_SRC_LSB       = 8;
  localparam int          BD_GATE_BIT      = 15;
  localparam int          BD_RST_BIT       = 16;

  // ==========================================================================
  // rtc source encodings and divider
  typedef enum logic [1:0] {
    RTC_SRC_NONE = 2'h0,
    RTC_SRC_SLOW = 2'h1,
    RTC_SRC_IRC  = 2'h2,
    RTC_SRC_FAST = 2'h3
  } rtc_src_t;
  localparam int          DIV_W            = 7;

  // backup domain state carried as one unit
  typedef struct packed {
    logic     bkp_rst;
    logic     rtc_gate;
    rtc_src_t rtc_src;
    logic     bypass;
    logic     enable;
  } bdctl_t;
  localparam bdctl_t      BDCTL_DEFAULT    = '{1'b0, 1'b0, RTC_SRC_NONE, 1'b0, 1'b0};

  // ==========================================================================
  // bus responses
  localparam logic [1:0]  RESP_OKAY        = 2'h0;
  localparam logic [1:0]  RESP_SLVERR      = 2'h2;

endpackage

`default_nettype wire

// *** logic/lsb_clock_ctl.sv ***
// low-speed bus clock gate register and backup domain clock control
// assumes oscillator and crystal clock levels arrive synchronous to clk,
// and that clock gate cells downstream latch their enable during the low phase
//
// How it works
// [R1] bits 29,28,27 gate dac, power unit and backup interface clocks
// [R2] bits 26,25 gate the two can controller clocks
// [R3] bits 22,21 gate the two i2c controller clocks
// [R4] bits 20 down to 17 gate the four serial port clocks
// [R5] bits 15,14 gate the two spi controller clocks
// [R6] bit 11 gates the window watchdog clock
// [R7] bits 5 down to 0 gate the six general timer clocks
// [R8] software keeps unused gate bits at zero; they read back zero
// [R9] backup control at 0x20 resets to 0x18 on backup domain reset only
// [R10] backup control accepts byte, half-word and word access
// [R11] oscillator, bypass, source and rtc gate survive system reset
// [R12] those fields change only while backup write unlock is set
// [R13] bit 16 holds the backup domain in reset while one
// [R14] bit 15 passes the rtc clock when one
// [R15] bits 9:8 pick none, slow crystal, internal 40k, fast crystal/128
// [R16] a nonzero rtc source is frozen until backup domain reset
// [R17] bit 2 puts the slow oscillator in bypass mode
// [R18] bit 0 enables slow oscillator; bit 1 reads its stable flag
// [R19] gate register at 0x1c resets to zero, every clock stopped
// [R20] bus gate enables change just after a rising edge, steady over the low phase; the rtc gate closes in any phase once rtc_want drops
// [R21] fast crystal divided by free 7-bit counter; rtc low with no source
//
// Implementation choice: register access over AXI4-Lite.
`default_nettype none

module lsb_clock_ctl
  import lsb_clock_pkg::*;
(
  // clock and resets
  input  wire logic              clk,
  input  wire logic              srst,
  input  wire logic              backup_por,
  // axi4-lite write address and data
  input  wire logic              awvalid,
  output logic                   awready,
  input  wire logic [ADDR_W-1:0] awaddr,
  input  wire logic [2:0]        awprot,
  input  wire logic              wvalid,
  output logic                   wready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  // axi4-lite write response
  output logic                   bvalid,
  input  wire logic              bready,
  output logic [1:0]             bresp,
  // axi4-lite read
  input  wire logic              arvalid,
  output logic                   arready,
  input  wire logic [ADDR_W-1:0] araddr,
  input  wire logic [2:0]        arprot,
  output logic                   rvalid,
  input  wire logic              rready,
  output logic [31:0]            rdata,
  output logic [1:0]             rresp,
  // power controller and oscillators
  input  wire logic              backup_write_unlock,
  input  wire logic              slow_osc_ready,
  input  wire logic              slow_crystal_clock,
  input  wire logic              internal_40k_clock,
  input  wire logic              fast_crystal_clock,
  // clock enables and backup outputs
  output logic [31:0]            bus_clock_gates,
  output logic                   slow_osc_enable,
  output logic                   slow_osc_bypass,
  output logic                   backup_domain_reset,
  output logic                   rtc_clock
);

  // ==========================================================================
  // byte lane merge
  function automatic logic [31:0] merge_bytes(input logic [31:0] old_word,
                                               input logic [31:0] new_word,
                                               input logic [3:0]  strb);
    logic [31:0] res;
    res = old_word;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[8*b +: 8] = new_word[8*b +: 8];
      end
    end
    return res;
  endfunction

  // ==========================================================================
  // write channel state
  logic              aw_have_q;
  logic              aw_have_d;
  logic              w_have_q;
  logic              w_have_d;
  logic [ADDR_W-1:0] aw_addr_q;
  logic [31:0]       wdata_q;
  logic [3:0]        wstrb_q;
  logic              awready_q;
  logic              wready_q;
  logic              bvalid_q;
  logic              bvalid_d;
  logic [1:0]        bresp_q;

  // read channel state
  logic              arready_q;
  logic              rvalid_q;
  logic              rvalid_d;
  logic [31:0]       rdata_q;
  logic [1:0]        rresp_q;

  // register state
  logic [31:0]       gates_q;
  logic [31:0]       gates_out_q;
  bdctl_t            bd_q;
  bdctl_t            bd_d;
  logic              stable_q;

  // rtc path
  logic              fast_prev_q;
  logic [DIV_W-1:0]  div_q;
  logic              rtc_pass_q;
  logic              rtc_q;
  logic              bkp_rst_out_q;

  // ==========================================================================
  // handshake decode
  wire aw_take   = awvalid & awready_q;
  wire w_take    = wvalid & wready_q;
  wire wr_do     = aw_have_q & w_have_q & ~bvalid_q;
  wire ar_take   = arvalid & arready_q;
  wire [ADDR_W-1:0] wr_word = {aw_addr_q[ADDR_W-1:2], 2'b00};
  wire [ADDR_W-1:0] rd_word = {araddr[ADDR_W-1:2], 2'b00};
  wire wr_hit_gates = (wr_word == GATES_OFFSET);
  wire wr_hit_bd    = (wr_word == BDCTL_OFFSET);
  wire rd_hit_gates = (rd_word == GATES_OFFSET);
  wire rd_hit_bd    = (rd_word == BDCTL_OFFSET);
  wire wr_hit       = wr_hit_gates | wr_hit_bd;
  wire rd_hit       = rd_hit_gates | rd_hit_bd;

  // next state of the handshake flags; readies follow from them so they are flops
  assign aw_have_d = wr_do ? 1'b0 : (aw_have_q | aw_take);
  assign w_have_d  = wr_do ? 1'b0 : (w_have_q | w_take);
  assign bvalid_d  = wr_do | (bvalid_q & ~bready);
  assign rvalid_d  = ar_take | (rvalid_q & ~rready);

  // ==========================================================================
  // register read view
  wire [31:0] bd_word = BDCTL_RSVD_READ
                      | ({31'h0, bd_q.enable}   << BD_ENABLE_BIT)
                      | ({31'h0, stable_q}      << BD_STABLE_BIT)
                      | ({31'h0, bd_q.bypass}   << BD_BYPASS_BIT)
                      | ({30'h0, bd_q.rtc_src}  << BD_SRC_LSB)
                      | ({31'h0, bd_q.rtc_gate} << BD_GATE_BIT)
                      | ({31'h0, bd_q.bkp_rst}  << BD_RST_BIT);
  wire [31:0] rd_word_val = rd_hit_gates ? gates_q :
                            rd_hit_bd    ? bd_word : 32'h0000_0000;

  // merged write values; byte lanes make partial access work [R10]
  wire [31:0] gates_merged = merge_bytes(gates_q, wdata_q, wstrb_q);
  wire [31:0] bd_merged    = merge_bytes(bd_word, wdata_q, wstrb_q);
  wire        gates_wr     = wr_do & wr_hit_gates;
  wire        bd_wr        = wr_do & wr_hit_bd;
  wire        bkp_hold     = backup_por | bd_q.bkp_rst;

  // ==========================================================================
  // write address and data capture, either order
  always_ff @(posedge clk) begin
    if (srst) begin
      aw_have_q <= 1'b0;
      w_have_q  <= 1'b0;
      aw_addr_q <= '0;
      wdata_q   <= 32'h0000_0000;
      wstrb_q   <= 4'h0;
    end else begin
      aw_have_q <= aw_have_d;
      w_have_q  <= w_have_d;
      if (aw_take) begin
        aw_addr_q <= awaddr;
      end
      if (w_take) begin
        wdata_q <= wdata;
        wstrb_q <= wstrb;
      end
    end
  end

  // write readies and response; one write outstanding at a time
  always_ff @(posedge clk) begin
    if (srst) begin
      awready_q <= 1'b0;
      wready_q  <= 1'b0;
      bvalid_q  <= 1'b0;
      bresp_q   <= RESP_OKAY;
    end else begin
      awready_q <= ~aw_have_d & ~bvalid_d;
      wready_q  <= ~w_have_d & ~bvalid_d;
      bvalid_q  <= bvalid_d;
      if (wr_do) begin
        bresp_q <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

  // read path answers at the edge that takes the address
  always_ff @(posedge clk) begin
    if (srst) begin
      arready_q <= 1'b0;
      rvalid_q  <= 1'b0;
      rdata_q   <= 32'h0000_0000;
      rresp_q   <= RESP_OKAY;
    end else begin
      arready_q <= ~rvalid_d;
      rvalid_q  <= rvalid_d;
      if (ar_take) begin
        rdata_q <= rd_word_val;
        rresp_q <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

  // ==========================================================================
  // clock gate register follows system reset
  always_ff @(posedge clk) begin
    if (srst) begin
      gates_q <= GATES_RESET;                                   // [R19]
    end else if (gates_wr) begin
      gates_q <= gates_merged & GATES_WR_MASK;                  // [R8]
    end
  end

  // one enable flop per gate; each changes just after a rising edge and is
  // steady across the whole low phase in which the gate cell latches it
  for (genvar g = 0; g < 32; g++) begin : gen_gate
    always_ff @(posedge clk) begin
      if (srst) begin
        gates_out_q[g] <= GATES_RESET[g];
      end else begin
        gates_out_q[g] <= gates_q[g] & GATES_WR_MASK[g];        // [R1] [R2] [R3] [R4] [R5] [R6] [R7] [R20]
      end
    end
  end

  // ==========================================================================
  // backup control next state; system reset deliberately absent
  always_comb begin
    bd_d = bd_q;
    if (backup_por) begin
      bd_d = BDCTL_DEFAULT;                                     // [R9]
    end else begin
      if (bd_q.bkp_rst) begin
        bd_d = BDCTL_DEFAULT;                                   // [R13]
        bd_d.bkp_rst = 1'b1;
      end
      if (bd_wr) begin
        bd_d.bkp_rst = bd_merged[BD_RST_BIT];                   // [R13]
        if (backup_write_unlock && !bd_q.bkp_rst) begin         // [R12]
          bd_d.enable   = bd_merged[BD_ENABLE_BIT];             // [R18]
          bd_d.bypass   = bd_merged[BD_BYPASS_BIT];             // [R17]
          bd_d.rtc_gate = bd_merged[BD_GATE_BIT];               // [R14]
          if (bd_q.rtc_src == RTC_SRC_NONE) begin               // [R16]
            bd_d.rtc_src = rtc_src_t'(bd_merged[BD_SRC_LSB +: 2]);
          end
        end
      end
    end
  end

  // backup register survives srst; only the backup domain reset clears it
  always_ff @(posedge clk) begin
    bd_q <= bd_d;                                               // [R11]
  end

  // stable flag: hardware owned, read only, low while the oscillator is off
  always_ff @(posedge clk) begin
    if (backup_por) begin
      stable_q <= 1'b0;
    end else begin
      stable_q <= bd_q.enable & slow_osc_ready & ~bd_q.bkp_rst; // [R18]
    end
  end

  // ==========================================================================
  // fast crystal divider, counts each sampled rising edge
  wire fast_rise = fast_crystal_clock & ~fast_prev_q;
  always_ff @(posedge clk) begin
    if (srst) begin
      fast_prev_q <= 1'b0;
      div_q       <= '0;
    end else begin
      fast_prev_q <= fast_crystal_clock;
      if (fast_rise) begin
        div_q <= div_q + 7'h01;                                 // [R21]
      end
    end
  end

  // source mux; no source gives a steady low
  wire src_level = (bd_q.rtc_src == RTC_SRC_SLOW) ? slow_crystal_clock :
                   (bd_q.rtc_src == RTC_SRC_IRC)  ? internal_40k_clock :
                   (bd_q.rtc_src == RTC_SRC_FAST) ? div_q[DIV_W-1] : 1'b0;  // [R15]
  wire rtc_want  = bd_q.rtc_gate & (bd_q.rtc_src != RTC_SRC_NONE) & ~bkp_hold;

  // the rtc gate only opens while the selected level is low, so the rtc never
  // starts on a clipped high pulse; it closes at once when rtc_want drops, and opening lags up to half a period
  always_ff @(posedge clk) begin
    if (backup_por) begin
      rtc_pass_q <= 1'b0;
      rtc_q      <= 1'b0;
    end else begin
      if (!src_level || !rtc_want) begin
        rtc_pass_q <= rtc_want;                                 // [R14] [R20]
      end
      rtc_q <= src_level & rtc_pass_q & rtc_want;               // [R21]
    end
  end

  // backup domain reset out combines the backup reset and the software request
  always_ff @(posedge clk) begin
    bkp_rst_out_q <= bkp_hold;                                  // [R13]
  end

  // ==========================================================================
  // outputs, all from flops
  assign awready             = awready_q;
  assign wready              = wready_q;
  assign bvalid              = bvalid_q;
  assign bresp               = bresp_q;
  assign arready             = arready_q;
  assign rvalid              = rvalid_q;
  assign rdata               = rdata_q;
  assign rresp               = rresp_q;
  assign bus_clock_gates     = gates_out_q;
  assign slow_osc_enable     = bd_q.enable;
  assign slow_osc_bypass     = bd_q.bypass;
  assign backup_domain_reset = bkp_rst_out_q;
  assign rtc_clock           = rtc_q;

  // protection bits carry no meaning here
  wire unused_prot = ^{awprot, arprot};

  // ==========================================================================
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  gate_write_seen_a: assert property (                                  // [R1]
    (gates_wr && wstrb_q == 4'hf) |-> ##2 (bus_clock_gates == ($past(wdata_q, 2) & GATES_WR_MASK))
  ) else $error("gate write not reflected on clock enables");

  gate_reserved_a: assert property (                                    // [R8]
    (bus_clock_gates & ~GATES_WR_MASK) == 32'h0000_0000
  ) else $error("reserved clock enable bit driven");

  gate_reset_zero_a: assert property (@(posedge clk) disable iff (1'b0) // [R19]
    srst |=> (bus_clock_gates == GATES_RESET)
  ) else $error("clock enables not stopped by reset");

  bd_unlock_only_a: assert property (                                   // [R12]
    (!backup_write_unlock && !bkp_hold) |=> $stable({bd_q.enable, bd_q.bypass, bd_q.rtc_gate})
  ) else $error("protected backup field changed while locked");

  rtc_src_lock_a: assert property (                                     // [R16]
    (bd_q.rtc_src != RTC_SRC_NONE && !bkp_hold) |=> $stable(bd_q.rtc_src)
  ) else $error("rtc source changed after selection");

  bd_hold_default_a: assert property (                                  // [R13]
    bkp_hold |=> (bd_q.rtc_src == RTC_SRC_NONE && !bd_q.enable && !bd_q.rtc_gate
                  && backup_domain_reset)
  ) else $error("backup fields not defaulted during backup reset");

  osc_stable_a: assert property (                                       // [R18]
    (!bd_q.enable) |=> !bd_word[BD_STABLE_BIT]
  ) else $error("stable flag set with oscillator off");

  rtc_none_low_a: assert property (                                     // [R21]
    (bd_q.rtc_src == RTC_SRC_NONE)[*2] |-> !rtc_clock
  ) else $error("rtc clock toggles with no source");

  div_step_a: assert property (                                         // [R21]
    fast_rise |=> (div_q == $past(div_q) + 7'h01)
  ) else $error("divider missed a fast crystal edge");

  write_answer_a: assert property (                                     // write response two cycles after address and data are taken together
    (aw_take && w_take && !aw_have_q && !w_have_q) |-> ##1 wr_do ##1 bvalid
  ) else $error("write response not given two cycles after take");

endmodule

`default_nettype wire

// *** tb/tb_top.sv ***
// ==========================================================================
// self-checking bench for the low-speed bus clock gates and backup clock control
// assumes lsb_clock_pkg and lsb_clock_ctl are compiled first; one 50 MHz clock
`default_nettype none

module tb_top
  import lsb_clock_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int CYCLE_LIMIT = 20000;

  logic              clk, srst, backup_por;
  logic              awvalid, awready, wvalid, wready, bvalid, bready;
  logic [ADDR_W-1:0] awaddr, araddr;
  logic [31:0]       wdata, rdata, bus_clock_gates;
  logic [3:0]        wstrb;
  logic [1:0]        bresp, rresp;
  logic              arvalid, arready, rvalid, rready;
  logic              backup_write_unlock, slow_osc_ready;
  logic              slow_crystal_clock, fast_crystal_clock;
  logic              internal_40k_clock = 1'b0;
  logic              slow_osc_enable, slow_osc_bypass, backup_domain_reset, rtc_clock;
  logic [7:0]        osc_cnt = 8'h0;
  logic [2:0]        irc_cnt = 3'h0;
  int                cycles, fail_count, samples_checked;

  lsb_clock_ctl i_lsb_clock_ctl (
    .clk(clk), .srst(srst), .backup_por(backup_por),
    .awvalid(awvalid), .awready(awready), .awaddr(awaddr), .awprot(3'h0),
    .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
    .bvalid(bvalid), .bready(bready), .bresp(bresp),
    .arvalid(arvalid), .arready(arready), .araddr(araddr), .arprot(3'h0),
    .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
    .backup_write_unlock(backup_write_unlock), .slow_osc_ready(slow_osc_ready),
    .slow_crystal_clock(slow_crystal_clock), .internal_40k_clock(internal_40k_clock),
    .fast_crystal_clock(fast_crystal_clock), .bus_clock_gates(bus_clock_gates),
    .slow_osc_enable(slow_osc_enable), .slow_osc_bypass(slow_osc_bypass),
    .backup_domain_reset(backup_domain_reset), .rtc_clock(rtc_clock)
  );

  // ==========================================================================
  // clock, oscillator levels and watchdog
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // source levels have periods of 8, 12 and 2 cycles so counts come out whole
  always @(posedge clk) begin
    osc_cnt            <= osc_cnt + 8'h01;
    slow_crystal_clock <= osc_cnt[2];
    fast_crystal_clock <= osc_cnt[0];
    irc_cnt            <= (irc_cnt == 3'h5) ? 3'h0 : irc_cnt + 3'h1;
    if (irc_cnt == 3'h5) begin
      internal_40k_clock <= ~internal_40k_clock;
    end
  end

  // a hung handshake ends the run here rather than in each wait loop
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == CYCLE_LIMIT) begin
      fail_count++;
      test_done();
    end
  end

  // ==========================================================================
  // shared tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask

  task automatic test_done();
    $display("checks=%0d mismatches=%0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // address and data offered together, each released when taken
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                           output logic [1:0] r);
    logic aw_done, w_done;
    aw_done = 1'b0;
    w_done  = 1'b0;
    @(posedge clk);
    awaddr  <= a;
    wdata   <= d;
    wstrb   <= s;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    while (!(aw_done && w_done)) begin
      @(posedge clk);
      if (!aw_done && awready === 1'b1) begin
        aw_done = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w_done && wready === 1'b1) begin
        w_done = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge clk); while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
  endtask

  task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do @(posedge clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    while (rvalid !== 1'b1) @(posedge clk);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    logic [1:0]  r;
    axi_read(a, d, r);
    check(d, exp);
  endtask

  task automatic por_pulse();
    @(posedge clk);
    backup_por <= 1'b1;
    repeat (2) @(posedge clk);
    backup_por <= 1'b0;
  endtask

  // counts rtc high samples over n cycles
  task automatic count_high(input int n, output logic [31:0] h);
    h = 32'h0;
    repeat (n) begin
      @(posedge clk);
      h = h + {31'h0, rtc_clock};
    end
  endtask

  // ==========================================================================
  // scenarios
  task automatic t_reset_values();
    rd_chk(GATES_OFFSET, 32'h0);
    rd_chk(BDCTL_OFFSET, 32'h18);
    check(bus_clock_gates, 32'h0);
    $display("reset values done");
  endtask

  // every gate bit set and cleared; unused bits stay zero
  task automatic t_gates();
    logic [1:0] r;
    axi_write(GATES_OFFSET, 32'hffff_ffff, 4'hf, r);
    check({30'h0, r}, {30'h0, RESP_OKAY});
    @(posedge clk);
    check(bus_clock_gates, 32'h3e7e_c83f);
    rd_chk(GATES_OFFSET, 32'h3e7e_c83f);
    axi_write(GATES_OFFSET, 32'h0000_0000, 4'hf, r);
    @(posedge clk);
    check(bus_clock_gates, 32'h0);
    axi_write(GATES_OFFSET, 32'hffff_ffff, 4'h2, r);
    @(posedge clk);
    check(bus_clock_gates, 32'h0000_c800);
    $display("gates done");
  endtask

  task automatic t_bus_errors();
    logic [31:0] d;
    logic [1:0]  r;
    axi_write(8'h40, 32'hffff_ffff, 4'hf, r);
    check({30'h0, r}, {30'h0, RESP_SLVERR});
    axi_read(8'h24, d, r);
    check(d, 32'h0);
    check({30'h0, r}, {30'h0, RESP_SLVERR});
    $display("bus errors done");
  endtask

  task automatic t_byte_lanes();
    logic [1:0] r;
    axi_write(BDCTL_OFFSET, 32'hffff_ff05, 4'h1, r);
    rd_chk(BDCTL_OFFSET, 32'h1d);
    check({30'h0, slow_osc_bypass, slow_osc_enable}, 32'h3);
    slow_osc_ready <= 1'b1;
    repeat (3) @(posedge clk);
    rd_chk(BDCTL_OFFSET, 32'h1f);
    $display("byte lanes done");
  endtask

  task automatic t_protect();
    logic [1:0] r;
    backup_write_unlock <= 1'b0;
    axi_write(BDCTL_OFFSET, 32'h0000_8300, 4'hf, r);
    rd_chk(BDCTL_OFFSET, 32'h1f);
    backup_write_unlock <= 1'b1;
    $display("protect done");
  endtask

  // each source after a backup reset, then lock and gate off
  task automatic t_sources();
    logic [31:0] h;
    logic [1:0]  r;
    for (int s = 0; s < 4; s++) begin
      por_pulse();
      axi_write(BDCTL_OFFSET, 32'h0000_8000 | (32'(s) << 8), 4'h2, r);
      repeat (300) @(posedge clk);
      count_high((s == 3) ? 256 : 120, h);
      check(h, (s == 0) ? 32'h0 : ((s == 3) ? 32'h80 : 32'h3c));
    end
    axi_write(BDCTL_OFFSET, 32'h0000_8100, 4'h2, r);
    rd_chk(BDCTL_OFFSET, 32'h0000_8318);
    axi_write(BDCTL_OFFSET, 32'h0000_0300, 4'h2, r);
    repeat (4) @(posedge clk);
    count_high(256, h);
    check(h, 32'h0);
    $display("sources done");
  endtask

  task automatic t_sys_reset();
    logic [1:0] r;
    axi_write(BDCTL_OFFSET, 32'h0000_8305, 4'hf, r);
    axi_write(GATES_OFFSET, 32'hffff_ffff, 4'hf, r);
    @(posedge clk);
    srst <= 1'b1;
    repeat (3) @(posedge clk);
    check(bus_clock_gates, 32'h0);
    srst <= 1'b0;
    rd_chk(GATES_OFFSET, 32'h0);
    rd_chk(BDCTL_OFFSET, 32'h0000_831f);
    $display("system reset done");
  endtask

  task automatic t_bkp_reset();
    logic [1:0] r;
    axi_write(BDCTL_OFFSET, 32'h0001_0000, 4'h4, r);
    @(posedge clk);
    check({31'h0, backup_domain_reset}, 32'h1);
    rd_chk(BDCTL_OFFSET, 32'h0001_0018);
    axi_write(BDCTL_OFFSET, 32'h0000_0000, 4'hf, r);
    @(posedge clk);
    check({31'h0, backup_domain_reset}, 32'h0);
    rd_chk(BDCTL_OFFSET, 32'h18);
    $display("backup reset done");
  endtask

  // ==========================================================================
  // main sequence
  initial begin
    srst                <= 1'b1;
    backup_por          <= 1'b1;
    {awvalid, wvalid, bready, arvalid, rready} <= 5'h0;
    awaddr              <= 8'h0;
    araddr              <= 8'h0;
    wdata               <= 32'h0;
    wstrb               <= 4'h0;
    backup_write_unlock <= 1'b1;
    slow_osc_ready      <= 1'b0;
    fail_count           = 0;
    samples_checked      = 0;
    repeat (12) @(posedge clk);
    srst       <= 1'b0;
    backup_por <= 1'b0;
    t_reset_values();
    t_gates();
    t_bus_errors();
    t_byte_lanes();
    t_protect();
    t_sources();
    t_sys_reset();
    t_bkp_reset();
    test_done();
  end

endmodule

`default_nettype wire
